// ===== logic/frsr_top.sv
`timescale 1ns/100ps
module frsr_top (
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst,
    input  wire logic                      i_ce,
    input  wire frsr_pkg::frsr_bus_type    i_bus,
    input  wire frsr_pkg::frsr_mode_type   i_mode,
    input  wire logic                      i_soft_reset,
    input  wire logic                      i_media_change_n,
    input  wire logic                      i_dma_gate_bit,
    input  wire logic                      i_result_valid,
    input  wire frsr_pkg::frsr_status_type i_result_status,
    output logic [7:0]                     o_data,
    output logic [7:0]                     o_data_oe_n,
    output logic [1:0]                     o_rate_select,
    output logic                           o_precomp_disable,
    output logic                           o_density_select_pin
);
    logic [1:0] rate_q, rate_d;
    logic       precomp_q, precomp_d;
    logic       dens_q, dens_d;
    logic [7:0] data_q, data_d;
    logic [7:0] oe_n_q, oe_n_d;
    logic [7:0] dir_data;
    logic [7:0] dir_oe;
    logic [7:0] status_byte;

    frsr_dir_mux u_dir (
        .i_mode           (i_mode),
        .i_rate           (rate_q),
        .i_precomp        (precomp_q),
        .i_dma_gate       (i_dma_gate_bit),
        .i_media_change_n (i_media_change_n),
        .o_data           (dir_data),
        .o_oe_mask        (dir_oe)
    );

    frsr_status_enc u_st (
        .i_status (i_result_status),
        .o_byte   (status_byte)
    );

    // Config register; soft reset leaves it alone
    always_comb begin
        rate_d    = rate_q;
        precomp_d = precomp_q;
        dens_d    = dens_q;
        if (i_bus.wr && i_bus.addr == frsr_pkg::OFS_DIGITAL_INPUT) begin
            rate_d = i_bus.wdata[1:0];                                    // RULE11 RULE20
            if (i_mode == frsr_pkg::FRSR_MODE_THIRD) begin
                precomp_d = i_bus.wdata[frsr_pkg::BIT_PRECOMP];           // RULE13
            end
            dens_d = (i_bus.wdata[1:0] == frsr_pkg::RATE_500K) ||
                     (i_bus.wdata[1:0] == frsr_pkg::RATE_1M);             // RULE14
        end
    end

    // Read path
    always_comb begin
        data_d = 8'h00;
        oe_n_d = 8'hFF;
        if (i_bus.rd && i_bus.addr == frsr_pkg::OFS_DIGITAL_INPUT) begin
            data_d = dir_data;                                            // RULE1
            oe_n_d = ~dir_oe;                                             // RULE2
        end else if (i_bus.rd && i_bus.addr == frsr_pkg::OFS_DATA &&
                     i_result_valid) begin
            data_d = status_byte;                                         // RULE19
            oe_n_d = 8'h00;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rate_q    <= frsr_pkg::RATE_RESET;                            // RULE5 RULE7
            precomp_q <= 1'b0;                                            // RULE8
            dens_q    <= 1'b1;                                            // RULE14
            data_q    <= 8'h00;
            oe_n_q    <= 8'hFF;
        end else if (i_ce) begin
            rate_q    <= rate_d;
            precomp_q <= precomp_d;
            dens_q    <= dens_d;
            data_q    <= data_d;
            oe_n_q    <= oe_n_d;
        end
    end

    always_comb begin
        o_data               = data_q;
        o_data_oe_n          = oe_n_q;
        o_rate_select        = rate_q;
        o_precomp_disable    = precomp_q;
        o_density_select_pin = dens_q;
    end
endmodule

// ===== common/frsr_pkg.sv
// Overview of operation
// [RULE1] Offset 7 reads input register only
// [RULE2] Legacy read drives only bit 7
// [RULE3] Bit 7 is inverted media change
// [RULE4] Alternate bit 0 low for fast rates
// [RULE5] Alternate bits 2:1 rate, hardware reset 250K
// [RULE6] Alternate bits 6:3 read as one
// [RULE7] Third bits 1:0 rate, reset 10
// [RULE8] Third bit 2 returns precomp disable
// [RULE9] Third bit 3 returns DMA gate
// [RULE10] Third bits 6:4 read as zero
// [RULE11] Write offset 7 loads rate config
// [RULE12] Host writes zero to reserved bits
// [RULE13] Precomp disable stored, no function
// [RULE14] Density pin high after hardware reset
// [RULE15] Status0 bits 7:6 give termination code
// [RULE16] Status0 bit 5 marks seek done
// [RULE17] Status0 bit 4 marks equipment fault
// [RULE18] Status0 bit 3 zero, head, drive
// [RULE19] Result phase presents status bytes
// [RULE20] Rate codes 500,300,250,1M kbps
// [RULE21] Mode input selects input register layout
package frsr_pkg;
    localparam logic [2:0] OFS_DIGITAL_INPUT = 3'h7;
    localparam logic [2:0] OFS_DATA          = 3'h5;
    localparam logic [1:0] RATE_500K         = 2'h0;
    localparam logic [1:0] RATE_300K         = 2'h1;
    localparam logic [1:0] RATE_250K         = 2'h2;
    localparam logic [1:0] RATE_1M           = 2'h3;
    localparam logic [1:0] RATE_RESET        = RATE_250K;
    localparam int         BIT_MEDIA         = 7;
    localparam int         BIT_PRECOMP       = 2;
    localparam int         BIT_DMA_GATE      = 3;
    localparam logic [3:0] ALT_ONES          = 4'hF;
    localparam logic [2:0] THIRD_ZEROS       = 3'h0;
    localparam logic [7:0] LEGACY_OE_MASK    = 8'h80;
    localparam logic [7:0] ALL_OE_MASK       = 8'hFF;
    localparam logic [1:0] TERM_NORMAL       = 2'h0;
    localparam logic [1:0] TERM_ABNORMAL     = 2'h1;
    localparam logic [1:0] TERM_INVALID      = 2'h2;
    localparam logic [1:0] TERM_POLLING      = 2'h3;

    typedef enum logic [1:0] {
        FRSR_MODE_LEGACY,
        FRSR_MODE_ALTERNATE,
        FRSR_MODE_THIRD,
        FRSR_MODE_SPARE
    } frsr_mode_type;

    typedef struct packed {
        logic [1:0] termination_code;
        logic       seek_done;
        logic       equipment_fault;
        logic       head;
        logic [1:0] drive_number;
    } frsr_status_type;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } frsr_bus_type;
endpackage

// ===== logic/frsr_status_enc.sv
`timescale 1ns/100ps
module frsr_status_enc (
    input  wire frsr_pkg::frsr_status_type i_status,
    output logic [7:0]                     o_byte
);
    always_comb begin
        o_byte = {i_status.termination_code,    // RULE15
                  i_status.seek_done,           // RULE16
                  i_status.equipment_fault,     // RULE17
                  1'b0,                          // RULE18
                  i_status.head,
                  i_status.drive_number};
    end
endmodule

// ===== logic/frsr_dir_mux.sv
`timescale 1ns/100ps
module frsr_dir_mux (
    input  wire frsr_pkg::frsr_mode_type i_mode,
    input  wire logic [1:0]              i_rate,
    input  wire logic                    i_precomp,
    input  wire logic                    i_dma_gate,
    input  wire logic                    i_media_change_n,
    output logic [7:0]                   o_data,
    output logic [7:0]                   o_oe_mask
);
    logic media_change_flag;
    logic low_rate_class_flag;

    always_comb begin
        media_change_flag   = ~i_media_change_n;                          // RULE3
        low_rate_class_flag = (i_rate == frsr_pkg::RATE_250K) ||
                              (i_rate == frsr_pkg::RATE_300K);            // RULE4
        o_data    = 8'h00;
        o_oe_mask = frsr_pkg::ALL_OE_MASK;
        unique case (i_mode) // RULE21
            frsr_pkg::FRSR_MODE_ALTERNATE: begin
                o_data = {media_change_flag, frsr_pkg::ALT_ONES,
                          i_rate, low_rate_class_flag};                   // RULE5 RULE6
            end
            frsr_pkg::FRSR_MODE_THIRD: begin
                o_data = {media_change_flag, frsr_pkg::THIRD_ZEROS,
                          i_dma_gate, i_precomp, i_rate};                 // RULE7 RULE8 RULE9 RULE10
            end
            default: begin
                o_data    = {media_change_flag, 7'h00};
                o_oe_mask = frsr_pkg::LEGACY_OE_MASK;                     // RULE2
            end
        endcase
    end
endmodule

// ===== verif/frsr_check_sva.sv
`timescale 1ns/100ps
module frsr_check (
    input wire logic                      i_mclk,
    input wire logic                      i_rst,
    input wire logic                      i_ce,
    input wire frsr_pkg::frsr_bus_type    i_bus,
    input wire frsr_pkg::frsr_mode_type   i_mode,
    input wire logic                      i_media_change_n,
    input wire logic                      i_dma_gate_bit,
    input wire logic                      i_result_valid,
    input wire frsr_pkg::frsr_status_type i_result_status,
    input wire logic [7:0]                o_data,
    input wire logic [7:0]                o_data_oe_n,
    input wire logic [1:0]                o_rate_select,
    input wire logic                      o_precomp_disable,
    input wire logic                      o_density_select_pin
);
    wire       rd7 = i_ce && i_bus.rd && i_bus.addr == 3'h7;
    wire       wr7 = i_ce && i_bus.wr && i_bus.addr == 3'h7;
    wire [6:0] st  = i_result_status;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_oe; rd7 && i_mode inside {2'h0, 2'h3} |=> o_data_oe_n == 8'h7F; endproperty
    a_oe: assert property (p_oe) else $error("legacy mask");
    property p_b7; rd7 |=> o_data[7] == !$past(i_media_change_n); endproperty
    a_b7: assert property (p_b7) else $error("media bit");
    property p_alt; rd7 && i_mode == 2'h1 |=>
        o_data[6:0] == {4'hF, $past(o_rate_select), ^$past(o_rate_select)}; endproperty
    a_alt: assert property (p_alt) else $error("alternate");
    property p_thd; rd7 && i_mode == 2'h2 |=> o_data[6:0] == {3'h0,
        $past(i_dma_gate_bit), $past(o_precomp_disable), $past(o_rate_select)}; endproperty
    a_thd: assert property (p_thd) else $error("third");
    property p_ro; i_ce && !i_bus.rd |=> o_data_oe_n == 8'hFF; endproperty
    a_ro: assert property (p_ro) else $error("read only");
    property p_wr; wr7 |=> o_rate_select == $past(i_bus.wdata[1:0])
        && o_density_select_pin == !(^$past(i_bus.wdata[1:0])); endproperty
    a_wr: assert property (p_wr) else $error("config write");
    property p_hold; !wr7 |=> $stable(o_rate_select) && $stable(o_precomp_disable)
        && $stable(o_density_select_pin); endproperty
    a_hold: assert property (p_hold) else $error("config hold");
    property p_prc; wr7 && i_mode == 2'h2 |=>
        o_precomp_disable == $past(i_bus.wdata[2]); endproperty
    a_prc: assert property (p_prc) else $error("precomp");
    property p_st; i_ce && i_bus.rd && i_bus.addr == 3'h5 && i_result_valid |=>
        o_data == {$past(st[6:3]), 1'b0, $past(st[2:0])} && o_data_oe_n == 8'h00; endproperty
    a_st: assert property (p_st) else $error("status");
    cover property (rd7 && i_mode == 2'h2);
    cover property (wr7);
    cover property (i_bus.rd && i_result_valid);
endmodule

// ===== verif/frsr_host.sv
`timescale 1ns/100ps
module frsr_host (
    input  wire logic              i_mclk,
    output frsr_pkg::frsr_bus_type o_bus
);
    initial o_bus = '0;
    task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_bus <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge i_mclk);
        o_bus <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// ===== verif/floppy_rate_input_status_test.sv
`timescale 1ns/100ps
module floppy_rate_input_status_test;
    logic                      i_mclk, i_rst, i_soft_reset, i_media_change_n, i_dma_gate_bit;
    logic                      i_result_valid, o_precomp_disable, o_density_select_pin, p, i_ce;
    logic [7:0]                o_data, o_data_oe_n, e, k;
    logic [1:0]                o_rate_select;
    frsr_pkg::frsr_bus_type    bus;
    frsr_pkg::frsr_mode_type   mode;
    frsr_pkg::frsr_status_type st;
    int                        n_mismatch, total_checks;
    frsr_host host (.i_mclk(i_mclk), .o_bus(bus));
    frsr_top dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_bus(bus), .i_mode(mode),
        .i_soft_reset(i_soft_reset), .i_media_change_n(i_media_change_n),
        .i_dma_gate_bit(i_dma_gate_bit), .i_result_valid(i_result_valid),
        .i_result_status(st), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
        .o_rate_select(o_rate_select), .o_precomp_disable(o_precomp_disable),
        .o_density_select_pin(o_density_select_pin));
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        total_checks++;
        if (x !== g) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic cfg(input logic [7:0] x);
        chk("cfg", x, {4'h0, o_density_select_pin, o_precomp_disable, o_rate_select});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    initial begin
        #200000;
        n_mismatch++;
        stop_test;
    end
    initial begin
        i_rst = 1'b1;
        i_ce = 1'b1;
        i_soft_reset = 1'b0;
        i_media_change_n = 1'b1;
        i_dma_gate_bit = 1'b0;
        i_result_valid = 1'b0;
        mode = frsr_pkg::FRSR_MODE_LEGACY;
        st = '0;
        p = 1'b0;
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        #1;
        cfg(8'h0A);
        $display("reset test done");
        for (int m = 0; m < 4; m++) begin
            for (int r = 0; r < 4; r++) begin
                @(posedge i_mclk);
                mode <= frsr_pkg::frsr_mode_type'(m);
                i_media_change_n <= r[0];
                i_dma_gate_bit <= r[1];
                host.xfer(1'b1, 3'h7, {5'h00, r[0], r[1:0]});
                if (m == 2) p = r[0];
                host.xfer(1'b0, 3'h7, 8'h00);
                #1;
                cfg({4'h0, !(^r[1:0]), p, r[1:0]});
                chk("oe_n", (m % 3) ? 8'h00 : 8'h7F, o_data_oe_n);
                e = (m == 1) ? {!r[0], 4'hF, r[1:0], ^r[1:0]} : {!r[0], 3'h0, r[1], p, r[1:0]};
                k = (m % 3) ? 8'h7F : 8'h00;
                chk("dir_hi", e & 8'h80, o_data & 8'h80);
                chk("dir_lo", e & k, o_data & k);
            end
        end
        $display("input register test done");
        mode <= frsr_pkg::FRSR_MODE_THIRD;
        host.xfer(1'b1, 3'h7, 8'h05);
        @(posedge i_mclk);
        i_soft_reset <= 1'b1;
        @(posedge i_mclk);
        i_soft_reset <= 1'b0;
        #1;
        cfg(8'h05);
        i_rst <= 1'b1;
        @(posedge i_mclk);
        i_rst <= 1'b0;
        #1;
        cfg(8'h0A);
        $display("reset kinds test done");
        i_result_valid <= 1'b1;
        for (int t = 0; t < 4; t++) begin
            st <= 7'(t * 37);
            host.xfer(1'b0, 3'h5, 8'h00);
            #1;
            chk("status", {st[6:3], 1'b0, st[2:0]}, o_data);
        end
        i_result_valid <= 1'b0;
        host.xfer(1'b0, 3'h5, 8'h00);
        #1;
        chk("oe_idle", 8'hFF, o_data_oe_n);
        $display("status test done");
        @(posedge i_mclk);
        i_ce <= 1'b0;
        host.xfer(1'b1, 3'h7, 8'h00);
        #1;
        cfg(8'h0A);
        @(posedge i_mclk);
        i_ce <= 1'b1;
        $display("clock enable test done");
        stop_test;
    end
endmodule
bind frsr_top frsr_check chk_i (.*);
